// File: verilog/ffc_pkg.sv
// constants, types and helpers for the transform core
// assumes one 50 MHz clock and a block length of 16 complex samples
package ffc_pkg;
    localparam int N    = 16;
    localparam int AW   = 4;
    localparam int DW   = 16;
    localparam int IW   = 22;
    localparam int YW   = 24;
    localparam int CW   = 17;
    localparam int PW   = 48;
    localparam int EW   = 8;
    localparam int TWB  = 14;
    localparam int NTW  = 10;

    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_STAT = 8'h04;
    localparam int C_FIXED = 0;
    localparam int C_ORD   = 1;
    localparam int C_REORD = 3;
    localparam int C_FLOAT = 4;
    localparam int CTRL_W  = 5;
    localparam logic [CTRL_W-1:0] CTRL_RST = 5'h00;
    localparam logic [1:0] ORD_NAT = 2'h0;
    localparam logic [1:0] ORD_REV = 2'h1;
    localparam logic [1:0] ORD_DC  = 2'h2;
    localparam logic [AW-1:0] DC_FLIP = 4'h8;
    localparam logic [AW-1:0] LAST    = 4'hF;
    localparam logic [4:0] TWB_SH     = 5'h0E;

    typedef enum logic [3:0] {
        ST_LOAD = 4'h1,
        ST_CALC = 4'h2,
        ST_WAIT = 4'h4,
        ST_OUT  = 4'h8
    } ffc_st_t;

    typedef struct packed {
        logic signed [DW-1:0] re;
        logic signed [DW-1:0] im;
    } ffc_smp_t;

    typedef struct packed {
        logic signed [IW-1:0] re;
        logic signed [IW-1:0] im;
    } ffc_cplx_t;

    // twiddle W16^m = cos - j sin, 14 fraction bits
    localparam logic signed [CW-1:0] TW_RE [NTW] = '{
        17'h04000, 17'h03B21, 17'h02D41, 17'h0187E, 17'h00000,
        17'h1E782, 17'h1D2BF, 17'h1C4DF, 17'h1C000, 17'h1C4DF};
    localparam logic signed [CW-1:0] TW_IM [NTW] = '{
        17'h00000, 17'h1E782, 17'h1D2BF, 17'h1C4DF, 17'h1C000,
        17'h1C4DF, 17'h1D2BF, 17'h1E782, 17'h00000, 17'h0187E};

    function automatic logic [AW-1:0] ffc_rev(input logic [AW-1:0] a);
        logic [AW-1:0] r;
        for (int i = 0; i < AW; i++) r[i] = a[AW-1-i];
        return r;
    endfunction

    // magnitude bits of both parts, ored together
    function automatic logic [IW-1:0] ffc_mag(input ffc_cplx_t v);
        logic [IW-1:0] a;
        logic [IW-1:0] b;
        a = v.re[IW-1] ? ~v.re : v.re;
        b = v.im[IW-1] ? ~v.im : v.im;
        return a | b;
    endfunction

    // right shift that brings the block back inside DW signed bits
    function automatic logic [4:0] ffc_shift(input logic [IW-1:0] m);
        logic [4:0] r;
        r = 5'h00;
        for (int i = DW - 1; i < IW; i++) if (m[i]) r = 5'(i - DW + 2);
        return r;
    endfunction

    // round half to even while dropping sh low bits
    function automatic logic signed [IW-1:0] ffc_round(input logic signed [PW-1:0] x,
                                                       input logic [4:0] sh);
        logic signed [PW-1:0] q;
        logic [PW-1:0] half;
        logic [PW-1:0] rem;
        q    = x >>> sh;
        half = PW'(1) << (sh - 5'h01);
        rem  = PW'(x) & ((half << 1) - PW'(1));
        if (rem > half || (rem == half && q[0])) q = q + PW'(1);
        return q[IW-1:0];
    endfunction
endpackage

// File: verilog/ffc_core.sv
// memory based radix-4 transform core, 16 complex points, stream in and out
// assumes sink and source logic on the same clock and an apb master for setup
//
// Overview of operation
// - inverse result is not divided by N
// - radix-4 dif passes, radix-2 last if odd
// - shift block per prior pass range, sum exponent
// - drop fewest low bits before rounding products
// - iterative log4 N passes of radix-4 butterflies, one per cycle
// - fixed mode lets words grow per stage
// - fixed mode rounds products half to even
// - float request bit is only echoed, datapath stays fixed point
// - engine-only orders: nat-rev, rev-nat, dc-rev
// - reordering adds N cycles and no extra words
// - sample moves only when valid and ready
// - ready latency is zero
`timescale 1ns/1ps
`default_nettype none
// register map, byte addresses
//   ctrl: bit 0 growth mode, bits 2:1 input order, bit 3 reorder, bit 4 float request
//   stat: one-hot state, inverse flag, float echo, exponent in bits 15:8
// an unmapped address answers with an error and leaves ctrl alone,
// so a stray write cannot change the mode of a block in flight
// ctrl is read live while a block is loaded, computed and sent out,
// so software must only change it between blocks
//
// data flow of one block
//   load: 16 samples in, each stored at its index as mapped by the input order (natural, bit reversed or dc flipped)
//   calc: 8 cycles, two radix-4 passes of four butterflies
//   wait: 16 cycles, only when the reorder bit is set
//   out:  16 samples, each held until the downstream takes it
// loading of the next block starts once the last sample is registered,
// so it overlaps the drain of that last sample
//
// number format
//   input parts are 16-bit signed, output parts 22-bit signed
//   block mode shifts each pass output by the amount that would fit that pass's
//   input inside 16 signed bits, and reports the total right shift as a negative exponent
//   growth mode never shifts; 22 bits hold the full growth of 16 points
//   the float request bit is only echoed, the datapath stays fixed point
//
// apb timing
//   the setup cycle arms pready; the access cycle after it completes
//   read data is captured in setup, writes land at the access edge
//   transfers may follow back to back, no wait state is ever added
//
// stream timing
//   sink ready is a flop and drops the cycle after the 16th sample
//   first output valid 10 cycles after the last input, 26 with reorder
//   a stalled output sample keeps its data, flags and exponent
//
// limitations
//   the length is fixed at 16, so no radix-2 tail pass is built
//   one butterfly per cycle trades speed for a single set of adders
//   the inverse swaps real and imaginary parts on both sides,
//   which reuses the forward twiddles at no cost in logic
//   samples sent without a start marker fill from the current index

module ffc_core
    import ffc_pkg::*;
(
    input  wire logic             MCLK_I,
    input  wire logic             SRST_I,
    input  wire logic             PSEL_I,
    input  wire logic             PENABLE_I,
    input  wire logic             PWRITE_I,
    input  wire logic [7:0]       PADDR_I,
    input  wire logic [31:0]      PWDATA_I,
    output logic                  PREADY_O,
    output logic [31:0]           PRDATA_O,
    output logic                  PSLVERR_O,
    input  wire logic             SINK_VALID_I,
    input  wire logic             SINK_SOP_I,
    input  wire logic             SINK_EOP_I,
    input  wire logic             SINK_INVERSE_I,
    input  wire ffc_smp_t         SINK_I,
    output logic                  SINK_READY_O,
    output logic                  SOURCE_VALID_O,
    output logic                  SOURCE_SOP_O,
    output logic                  SOURCE_EOP_O,
    output ffc_cplx_t             SOURCE_O,
    output logic signed [EW-1:0]  SOURCE_EXP_O,
    input  wire logic             SOURCE_READY_I
);
    typedef struct packed {
        // sequencing
        ffc_st_t               st;
        logic [AW-1:0]         cnt;
        logic                  pass;
        logic [1:0]            grp;
        logic                  inv;
        // block scaling
        logic [IW-1:0]         mag;
        logic [4:0]            shift;
        logic signed [EW-1:0]  expo;
        // sample memory, one complex word per point
        ffc_cplx_t [N-1:0]     mem;
        // stream side outputs
        logic                  in_rdy;
        logic                  o_valid;
        logic                  o_sop;
        logic                  o_eop;
        ffc_cplx_t             o_dat;
        logic signed [EW-1:0]  o_exp;
        // apb side outputs and the control register
        logic                  pready;
        logic [31:0]           prdata;
        logic                  pslverr;
        logic [CTRL_W-1:0]     ctrl;
    } ffc_state_t;

    ffc_state_t r_ff;
    ffc_state_t nxt_r;

    // next state of the whole block
    always_comb begin
        // working values of the pass; each is set before any use,
        // so no latch is inferred on any path
        logic [AW-1:0]        idx;
        logic [AW-1:0]        pos;
        logic [AW-1:0]        ri [4];
        logic [3:0]           e;
        logic                 cur_inv;
        logic                 fixed_m;
        logic                 out_nat;
        ffc_cplx_t            v;
        ffc_cplx_t            x [4];
        logic signed [YW-1:0] yr [4];
        logic signed [YW-1:0] yi [4];
        logic [IW-1:0]        m;
        logic [4:0]           sh;
        nxt_r   = r_ff;
        idx     = '0;
        pos     = '0;
        e       = '0;
        v       = '0;
        m       = '0;
        sh      = '0;
        cur_inv = r_ff.inv;
        fixed_m = r_ff.ctrl[C_FIXED];
        // reordering flips the engine-only output order
        out_nat = (r_ff.ctrl[C_ORD +: 2] == ORD_REV) ^ r_ff.ctrl[C_REORD];
        // pass 0 takes stride-4 groups, pass 1 takes four neighbours
        for (int q = 0; q < 4; q++) begin
            ri[q] = r_ff.pass ? {r_ff.grp, 2'(q)} : {2'(q), r_ff.grp};
            x[q]  = r_ff.mem[ri[q]];
            yr[q] = '0;
            yi[q] = '0;
        end

        // apb slave: setup cycle arms pready, access completes one edge later
        nxt_r.pready  = 1'b0;
        nxt_r.pslverr = 1'b0;
        if (PSEL_I && !PENABLE_I) begin
            nxt_r.pready  = 1'b1;
            nxt_r.pslverr = (PADDR_I != A_CTRL) && (PADDR_I != A_STAT);
            nxt_r.prdata  = '0;
            if (PADDR_I == A_CTRL) begin
                nxt_r.prdata[CTRL_W-1:0] = r_ff.ctrl;
            end
            if (PADDR_I == A_STAT) begin
                nxt_r.prdata = {16'h0000, 8'(r_ff.expo), 2'b00,
                                r_ff.ctrl[C_FLOAT], r_ff.inv, 4'(r_ff.st)};
            end
        end
        if (PSEL_I && PENABLE_I && r_ff.pready && PWRITE_I && PADDR_I == A_CTRL) begin
            nxt_r.ctrl = PWDATA_I[CTRL_W-1:0];
        end

        // the downstream takes a held sample when it is ready
        if (r_ff.o_valid && SOURCE_READY_I) begin
            nxt_r.o_valid = 1'b0;
        end

        unique case (r_ff.st)
            ST_LOAD: begin
                // ready is a flop, so a transfer is exactly valid and ready
                if (SINK_VALID_I && r_ff.in_rdy) begin
                    idx = SINK_SOP_I ? '0 : r_ff.cnt;
                    if (SINK_SOP_I) begin
                        cur_inv   = SINK_INVERSE_I;
                        nxt_r.inv = SINK_INVERSE_I;
                    end
                    // plain fixed-point input, block exponent starts at zero
                    v.re = IW'(SINK_I.re);
                    v.im = IW'(SINK_I.im);
                    // inverse as swap-forward-swap; no division by N is ever made
                    if (cur_inv) v = {v.im, v.re};
                    unique case (r_ff.ctrl[C_ORD +: 2])
                        ORD_REV: pos = ffc_rev(idx);
                        ORD_DC:  pos = idx ^ DC_FLIP;
                        default: pos = idx;
                    endcase
                    nxt_r.mem[pos] = v;
                    m = ffc_mag(v) | ((idx == '0) ? '0 : r_ff.mag);
                    nxt_r.mag = m;
                    nxt_r.cnt = idx + 4'h1;
                    if (idx == LAST) begin
                        nxt_r.st     = ST_CALC;
                        nxt_r.in_rdy = 1'b0;
                        nxt_r.pass   = 1'b0;
                        nxt_r.grp    = 2'h0;
                        nxt_r.expo   = '0;
                        nxt_r.shift  = fixed_m ? 5'h00 : ffc_shift(m);
                    end
                end
            end
            ST_CALC: begin
                // one radix-4 dif butterfly per cycle, in place
                // pass 0 rotates output q of group g by w^(q*g); pass 1 needs none
                // this pass's shift was measured as the load or the previous pass ended
                yr[0] = YW'(x[0].re) + YW'(x[1].re) + YW'(x[2].re) + YW'(x[3].re);
                yi[0] = YW'(x[0].im) + YW'(x[1].im) + YW'(x[2].im) + YW'(x[3].im);
                yr[1] = YW'(x[0].re) + YW'(x[1].im) - YW'(x[2].re) - YW'(x[3].im);
                yi[1] = YW'(x[0].im) - YW'(x[1].re) - YW'(x[2].im) + YW'(x[3].re);
                yr[2] = YW'(x[0].re) - YW'(x[1].re) + YW'(x[2].re) - YW'(x[3].re);
                yi[2] = YW'(x[0].im) - YW'(x[1].im) + YW'(x[2].im) - YW'(x[3].im);
                yr[3] = YW'(x[0].re) - YW'(x[1].im) - YW'(x[2].re) + YW'(x[3].im);
                yi[3] = YW'(x[0].im) + YW'(x[1].re) - YW'(x[2].im) - YW'(x[3].re);
                // block shift folds into the product rounding: fewest bits dropped
                sh = TWB_SH + r_ff.shift;
                m  = (r_ff.grp == 2'h0) ? '0 : r_ff.mag;
                for (int q = 0; q < 4; q++) begin
                    e = r_ff.pass ? 4'h0 : 4'(q * r_ff.grp);
                    // convergent rounding; fixed mode keeps all growth in IW
                    v.re = ffc_round(PW'(yr[q]) * PW'(TW_RE[e]) - PW'(yi[q]) * PW'(TW_IM[e]), sh);
                    v.im = ffc_round(PW'(yr[q]) * PW'(TW_IM[e]) + PW'(yi[q]) * PW'(TW_RE[e]), sh);
                    // outputs 1 and 2 swap places so the block ends bit reversed
                    nxt_r.mem[ri[{q[0], q[1]}]] = v;
                    m = m | ffc_mag(v);
                end
                nxt_r.mag = m;
                nxt_r.grp = r_ff.grp + 2'h1;
                if (r_ff.grp == 2'h3) begin
                    nxt_r.expo  = r_ff.expo - EW'(r_ff.shift);
                    nxt_r.shift = fixed_m ? 5'h00 : ffc_shift(m);
                    nxt_r.pass  = 1'b1;
                    nxt_r.cnt   = '0;
                    if (r_ff.pass) begin
                        nxt_r.st = r_ff.ctrl[C_REORD] ? ST_WAIT : ST_OUT;
                    end
                end
            end
            ST_WAIT: begin
                // reordered outputs cost N more cycles of latency
                // the buffer is the sample memory itself, read in the other order,
                // so the cost is time only and no second memory is needed
                nxt_r.cnt = r_ff.cnt + 4'h1;
                if (r_ff.cnt == LAST) nxt_r.st = ST_OUT;
            end
            ST_OUT: begin
                // a stalled sample stays in the output flops; memory is not read again
                // until the downstream has taken it, so nothing can be skipped
                if (!r_ff.o_valid || SOURCE_READY_I) begin
                    v = r_ff.mem[out_nat ? ffc_rev(r_ff.cnt) : r_ff.cnt];
                    nxt_r.o_dat   = r_ff.inv ? {v.im, v.re} : v;
                    nxt_r.o_valid = 1'b1;
                    nxt_r.o_sop   = (r_ff.cnt == '0);
                    nxt_r.o_eop   = (r_ff.cnt == LAST);
                    // every sample of the block carries the block exponent
                    nxt_r.o_exp   = r_ff.expo;
                    nxt_r.cnt     = r_ff.cnt + 4'h1;
                    if (r_ff.cnt == LAST) begin
                        nxt_r.st     = ST_LOAD;
                        nxt_r.in_rdy = 1'b1;
                    end
                end
            end
        endcase
    end

    // single register stage for all state
    // reset leaves the core ready for a block, with ctrl cleared
    always_ff @(posedge MCLK_I) begin
        if (SRST_I) begin
            r_ff        <= '0;
            r_ff.st     <= ST_LOAD;
            r_ff.in_rdy <= 1'b1;
            r_ff.ctrl   <= CTRL_RST;
        end else begin
            r_ff <= nxt_r;
        end
    end

    // outputs straight from the state flops
    // no logic sits between a flop and a pin, which keeps output timing simple
    assign PREADY_O       = r_ff.pready;
    assign PRDATA_O       = r_ff.prdata;
    assign PSLVERR_O      = r_ff.pslverr;
    assign SINK_READY_O   = r_ff.in_rdy;
    assign SOURCE_VALID_O = r_ff.o_valid;
    assign SOURCE_SOP_O   = r_ff.o_sop;
    assign SOURCE_EOP_O   = r_ff.o_eop;
    assign SOURCE_O       = r_ff.o_dat;
    assign SOURCE_EXP_O   = r_ff.o_exp;
endmodule

`default_nettype wire

// File: bench/ffc_core_asserts.sv
// port checker for the transform core
// assumes a bind from the bench top, one clock and a synchronous reset
`timescale 1ns/1ps
`default_nettype none
module ffc_core_asserts
    import ffc_pkg::*;
(
    input wire logic                  MCLK_I,
    input wire logic                  SRST_I,
    input wire logic                  PSEL_I,
    input wire logic                  PENABLE_I,
    input wire logic                  PWRITE_I,
    input wire logic [7:0]            PADDR_I,
    input wire logic [31:0]           PWDATA_I,
    input wire logic                  PREADY_O,
    input wire logic [31:0]           PRDATA_O,
    input wire logic                  PSLVERR_O,
    input wire logic                  SINK_VALID_I,
    input wire logic                  SINK_SOP_I,
    input wire logic                  SINK_EOP_I,
    input wire logic                  SINK_INVERSE_I,
    input wire ffc_smp_t              SINK_I,
    input wire logic                  SINK_READY_O,
    input wire logic                  SOURCE_VALID_O,
    input wire logic                  SOURCE_SOP_O,
    input wire logic                  SOURCE_EOP_O,
    input wire ffc_cplx_t             SOURCE_O,
    input wire logic signed [EW-1:0]  SOURCE_EXP_O,
    input wire logic                  SOURCE_READY_I
);
    logic [3:0]        idx_ff;
    logic [CTRL_W-1:0] ctrl_ff;
    wire               take = SINK_VALID_I && SINK_READY_O;
    wire               last = take && (SINK_SOP_I ? 4'h0 : idx_ff) == LAST;
    wire               wr_c = PSEL_I && PENABLE_I && PREADY_O && PWRITE_I && PADDR_I == A_CTRL;
    // shadows of the load index and of ctrl, so timing can be tied to the mode
    always_ff @(posedge MCLK_I) begin
        if (SRST_I) begin
            idx_ff  <= 4'h0;
            ctrl_ff <= CTRL_RST;
        end else begin
            if (take) idx_ff <= (SINK_SOP_I ? 4'h0 : idx_ff) + 4'h1;
            if (wr_c) ctrl_ff <= PWDATA_I[CTRL_W-1:0];
        end
    end
    default clocking @(posedge MCLK_I); endclocking
    default disable iff (SRST_I);
    apb_zero_wait_a: assert property (PSEL_I && !PENABLE_I |=> PREADY_O)
        else $error("apb answer late");
    apb_err_a: assert property (PREADY_O |-> PSLVERR_O == (PADDR_I != A_CTRL && PADDR_I != A_STAT))
        else $error("apb error flag wrong");
    ctrl_read_a: assert property (PREADY_O && !PWRITE_I && PADDR_I == A_CTRL |-> PRDATA_O == 32'(ctrl_ff))
        else $error("ctrl readback wrong");
    sink_close_a: assert property (last |=> !SINK_READY_O)
        else $error("ready still high after block");
    src_hold_a: assert property (SOURCE_VALID_O && !SOURCE_READY_I |=> SOURCE_VALID_O && $stable(SOURCE_O))
        else $error("stalled sample changed");
    exp_block_a: assert property (SOURCE_VALID_O && SOURCE_READY_I && !SOURCE_EOP_O |=> SOURCE_VALID_O && !SOURCE_SOP_O && $stable(SOURCE_EXP_O))
        else $error("exponent or framing broke in block");
    fixed_exp_a: assert property (ctrl_ff[C_FIXED] && SOURCE_VALID_O |-> SOURCE_EXP_O == 8'sh00)
        else $error("exponent in growth mode");
    eng_lat_a: assert property (last && !ctrl_ff[C_REORD] |=>
        !SOURCE_VALID_O ##1 !SOURCE_VALID_O [*8] ##1 SOURCE_VALID_O)
        else $error("engine-only latency wrong");
    reord_lat_a: assert property (last && ctrl_ff[C_REORD] |=>
        !SOURCE_VALID_O ##1 !SOURCE_VALID_O [*8] ##17 SOURCE_VALID_O)
        else $error("reorder latency wrong");
    cover property (last && ctrl_ff[C_REORD]);
    cover property (SOURCE_VALID_O && !SOURCE_READY_I);
    cover property (PREADY_O && PSLVERR_O);
    cover property (SOURCE_VALID_O && SOURCE_EXP_O != 8'sh00);
endmodule
`default_nettype wire

// File: bench/ffc_sink_peer.sv
// downstream sink model: takes finished blocks, stalling on request
// assumes the core's clock; stall makes ready toggle every cycle
`timescale 1ns/1ps
`default_nettype none
module ffc_sink_peer
    import ffc_pkg::*;
(
    input  wire logic                 clk_i,
    input  wire logic                 rst_i,
    input  wire logic                 stall_i,
    input  wire logic                 valid_i,
    input  wire logic                 sop_i,
    input  wire logic                 eop_i,
    input  wire ffc_cplx_t            data_i,
    input  wire logic signed [EW-1:0] exp_i,
    output logic                      ready_o
);
    logic                 tog_ff  = 1'b0;
    int                   n_tot   = 0;
    int                   seq_err = 0;
    ffc_cplx_t            got [N];
    logic signed [EW-1:0] got_exp [N];
    // prompt answer, or every other cycle to exercise the core's hold logic
    assign ready_o = stall_i ? tog_ff : 1'b1;
    // a sample leaves only on valid and ready together
    always @(posedge clk_i) begin
        tog_ff <= rst_i ? 1'b0 : !tog_ff;
        if (!rst_i && valid_i && ready_o) begin
            got[n_tot % N]     <= data_i;
            got_exp[n_tot % N] <= exp_i;
            if (sop_i !== (n_tot % N == 0) || eop_i !== (n_tot % N == N - 1)) seq_err <= seq_err + 1;
            n_tot <= n_tot + 1;
        end
    end
endmodule
`default_nettype wire

// File: bench/ffc_core_tb.sv
// bench for the transform core: apb setup, then blocks in every order and direction
// assumes the sink peer downstream; the sample source is driven here
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, sn) begin checks_done++; if ((sn) !== (ex)) begin n_fail++; $display("mismatch %s expected %0h seen %0h", nm, ex, sn); end end
module ffc_core_tb;
    import ffc_pkg::*;
    logic        MCLK_I = 1'b0, SRST_I = 1'b1, PSEL_I = 1'b0, PENABLE_I = 1'b0, PWRITE_I = 1'b0;
    logic [7:0]  PADDR_I = 8'h00;
    logic [31:0] PWDATA_I = 32'h0, PRDATA_O, q;
    logic        SINK_VALID_I = 1'b0, SINK_SOP_I = 1'b0, SINK_EOP_I = 1'b0, SINK_INVERSE_I = 1'b0;
    ffc_smp_t    SINK_I = 32'h0;
    logic        PREADY_O, PSLVERR_O, SINK_READY_O, SOURCE_VALID_O, SOURCE_SOP_O, SOURCE_EOP_O;
    ffc_cplx_t   SOURCE_O;
    logic signed [EW-1:0] SOURCE_EXP_O;
    logic        SOURCE_READY_I, e, stall = 1'b0;
    int          n_fail = 0, checks_done = 0, nb = 0;
    always #10 MCLK_I = ~MCLK_I;
    ffc_core uut (.*);
    ffc_sink_peer peer (.clk_i(MCLK_I), .rst_i(SRST_I), .stall_i(stall), .valid_i(SOURCE_VALID_O),
        .sop_i(SOURCE_SOP_O), .eop_i(SOURCE_EOP_O), .data_i(SOURCE_O), .exp_i(SOURCE_EXP_O),
        .ready_o(SOURCE_READY_I));
    function automatic logic [3:0] flip(input logic [3:0] a);
        return {a[0], a[1], a[2], a[3]};
    endfunction
    // half scale times j to the n: one exact bin, large enough to force a block shift
    function automatic ffc_smp_t tone(input logic [3:0] n);
        ffc_smp_t s;
        s.re = n[0] ? 16'sh0000 : (n[1] ? -16'sh4000 : 16'sh4000);
        s.im = n[0] ? (n[1] ? -16'sh4000 : 16'sh4000) : 16'sh0000;
        return s;
    endfunction
    task automatic test_done;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // one apb transfer; request held until pready is seen high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge MCLK_I);
        PSEL_I    <= 1'b1;
        PENABLE_I <= 1'b0;
        PWRITE_I  <= wr;
        PADDR_I   <= a;
        PWDATA_I  <= d;
        @(posedge MCLK_I);
        PENABLE_I <= 1'b1;
        do @(posedge MCLK_I); while (PREADY_O !== 1'b1);
        q = PRDATA_O;
        e = PSLVERR_O;
        PSEL_I    <= 1'b0;
        PENABLE_I <= 1'b0;
    endtask
    task automatic run_block(input logic fx, input logic [1:0] od, input logic ro, input logic iv);
        logic [3:0]         at;
        logic signed [31:0] sc;
        apb(1'b1, A_CTRL, 32'(ro) << C_REORD | 32'(od) << C_ORD | 32'(fx) << C_FIXED);
        // direction rides only with the first sample
        for (int p = 0; p < N; p++) begin
            SINK_VALID_I   <= 1'b1;
            SINK_SOP_I     <= (p == 0);
            SINK_EOP_I     <= (p == N - 1);
            SINK_INVERSE_I <= (p == 0) ? iv : !iv;
            SINK_I <= tone(od == ORD_REV ? flip(4'(p)) : (od == ORD_DC ? 4'(p) ^ DC_FLIP : 4'(p)));
            do @(posedge MCLK_I); while (SINK_READY_O !== 1'b1);
        end
        SINK_VALID_I <= 1'b0;
        SINK_I       <= ~SINK_I;
        stall        <= iv ^ ro;
        nb++;
        while (peer.n_tot < nb * N) @(posedge MCLK_I);
        at = ((od == ORD_REV) ^ ro) ? (iv ? 4'hC : 4'h4) : flip(iv ? 4'hC : 4'h4);
        for (int k = 0; k < N; k++) begin
            sc = 32'(peer.got[k].re);
            sc = peer.got_exp[k] < 0 ? sc <<< -peer.got_exp[k] : sc >>> peer.got_exp[k];
            `CHK("bin real", (k == at) ? 32'sh0004_0000 : 32'sh0, sc)
            `CHK("bin imag", 22'sh0, peer.got[k].im)
            `CHK("block exponent", fx ? 8'sh00 : 8'shFE, peer.got_exp[k])
        end
        `CHK("block framing", 0, peer.seq_err)
        $display("block done fixed %0d order %0d reorder %0d inverse %0d", fx, od, ro, iv);
    endtask
    // registers first, then every mode, order and direction
    initial begin
        repeat (10) @(posedge MCLK_I);
        SRST_I <= 1'b0;
        apb(1'b0, A_CTRL, 32'h0);
        `CHK("ctrl reset", 32'(CTRL_RST), q)
        apb(1'b0, A_STAT, 32'h0);
        `CHK("state load", 4'h1, q[3:0])
        apb(1'b1, 8'h08, 32'hFFFF_FFFF);
        `CHK("unmapped error", 1'b1, e)
        apb(1'b1, A_CTRL, 32'h0000_001F);
        apb(1'b0, A_CTRL, 32'h0);
        `CHK("ctrl readback", 32'h0000_001F, q)
        apb(1'b0, A_STAT, 32'h0);
        `CHK("float echo", 1'b1, q[5])
        $display("register test done");
        for (int f = 1; f >= 0; f--)
            for (int o = 0; o < 3; o++)
                for (int r = 0; r < 2; r++)
                    for (int i = 0; i < 2; i++) run_block(f[0], o[1:0], r[0], i[0]);
        test_done();
    end
    // hang guard, several times the expected run
    initial begin
        repeat (10000) @(posedge MCLK_I);
        n_fail++;
        test_done();
    end
endmodule
bind ffc_core ffc_core_asserts chk (.*);
`default_nettype wire
